// ### include/pwm_timer_pkg.sv
package pwm_timer_pkg;

  // ****************************************
  // Widths and channel count
  // ****************************************
  localparam int          CNT_W     = 8;
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam int          NUM_CH    = 2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0]  OFS_ENABLE = 8'h00;
  localparam logic [7:0]  OFS_POL    = 8'h04;
  localparam logic [7:0]  OFS_CTL    = 8'h08;
  localparam logic [7:0]  OFS_CNT0   = 8'h10;
  localparam logic [7:0]  OFS_PER0   = 8'h18;
  localparam logic [7:0]  OFS_DTY0   = 8'h20;
  localparam logic [7:0]  OFS_STRIDE = 8'h04;

  // ****************************************
  // Field positions in the control word
  // ****************************************
  localparam int          CTL_ALIGN_LSB = 0;
  localparam int          CTL_CLKSEL_LSB = 2;

  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [1:0]  RST_BITS  = 2'h0;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ### include/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
  import pwm_timer_pkg::*;
  logic              en;
  logic              pol;
  logic              center;
  logic              tick;
  logic              per_wr;
  logic              dty_wr;
  logic              cnt_wr;
  logic [CNT_W-1:0]  wdata;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  per_buf;
  logic [CNT_W-1:0]  dty_buf;
  logic              run;
  logic              wave;

  modport ctl (
    output en, pol, center, tick, per_wr, dty_wr, cnt_wr, wdata,
    input  cnt, per_buf, dty_buf, run, wave
  );
  modport tmr (
    input  en, pol, center, tick, per_wr, dty_wr, cnt_wr, wdata,
    output cnt, per_buf, dty_buf, run, wave
  );
endinterface

// ### logic/chan_timer.sv
`timescale 1ns/1ps
module chan_timer
  import pwm_timer_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  chan_if.tmr        c
);

  logic [CNT_W-1:0]  cnt_q, cnt_d, per_q, per_d, dty_q, dty_d;
  logic [CNT_W-1:0]  pb_q, pb_d, db_q, db_d;
  logic              up_q, up_d, run_q, run_d, wave_q, wave_d;
  logic              step, load;

  function automatic logic at_end(input logic [CNT_W-1:0] n,
                                  input logic [CNT_W-1:0] p);
    at_end = ({1'b0, n} + 9'h001) >= {1'b0, p};
  endfunction

  // ****************************************
  // Counter, latches and output flip-flop
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    per_d = per_q;
    dty_d = dty_q;
    pb_d = c.per_wr ? c.wdata : pb_q;
    db_d = c.dty_wr ? c.wdata : db_q;
    run_d = c.tick ? c.en : run_q;
    // Enable gates the tick too, so a stop bites at once
    step = c.tick & run_q & c.en;
    load = 1'b0;
    if (c.tick && per_q == RST_BYTE) begin
      cnt_d = RST_BYTE;
    end else if (step && !c.center) begin
      up_d = 1'b1;
      if (at_end(cnt_q, per_q)) begin
        cnt_d = RST_BYTE;
        load = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else if (step && up_q) begin
      if (cnt_q >= per_q) begin
        up_d = 1'b0;
        cnt_d = cnt_q - 8'h01;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else if (step) begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q <= 8'h01) begin
        cnt_d = RST_BYTE;
        up_d = 1'b1;
        load = 1'b1;
      end
    end
    if (c.cnt_wr) begin
      cnt_d = RST_BYTE;
      up_d = 1'b1;
      load = 1'b1;
    end
    // Disabled channel lets writes straight through
    if (load || !c.en) begin
      per_d = pb_d;
      dty_d = db_d;
    end
    // Output level starts at polarity, flips at duty
    wave_d = (per_d == RST_BYTE) ? c.pol :
             (c.pol ^ (cnt_d >= dty_d));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= RST_BYTE;
      up_q <= 1'b1;
      run_q <= 1'b0;
      per_q <= RST_BYTE;
      dty_q <= RST_BYTE;
      pb_q <= RST_BYTE;
      db_q <= RST_BYTE;
      wave_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      run_q <= run_d;
      per_q <= per_d;
      dty_q <= dty_d;
      pb_q <= pb_d;
      db_q <= db_d;
      wave_q <= wave_d;
    end
  end

  assign c.cnt = cnt_q;
  assign c.per_buf = pb_q;
  assign c.dty_buf = db_q;
  assign c.run = run_q;
  assign c.wave = wave_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_left_step;
    c.tick && run_q && c.en && !c.center && !c.cnt_wr && !c.per_wr &&
      per_q != RST_BYTE;
  endsequence

  a_gate_at_tick: assert property (@(posedge clk) disable iff (!rst_n)
    !c.tick |=> $stable(run_q))
    else $error("Enable sync moved without a tick");
  a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    ((!run_q || !c.en) && !c.cnt_wr && per_q != RST_BYTE) |=> $stable(cnt_q))
    else $error("Counter moved while stopped");
  a_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (c.cnt_wr && !c.per_wr) |=> (cnt_q == RST_BYTE && up_q &&
                                  per_q == $past(pb_q)))
    else $error("Counter write did not restart");
  a_direct_load: assert property (@(posedge clk) disable iff (!rst_n)
    (!c.en && c.per_wr) |=> per_q == $past(c.wdata))
    else $error("Disabled write missed active latch");
  a_buffer_held: assert property (@(posedge clk) disable iff (!rst_n)
    (c.en && c.per_wr && !c.cnt_wr && !c.tick) |=> $stable(per_q))
    else $error("Period took effect early");
  a_left_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (s_left_step and at_end(cnt_q, per_q)) |=>
      (cnt_q == RST_BYTE && per_q == $past(pb_q)))
    else $error("Period match did not wrap and reload");
  a_left_count: assert property (@(posedge clk) disable iff (!rst_n)
    (s_left_step and !at_end(cnt_q, per_q)) |=>
      cnt_q == $past(cnt_q) + 8'h01)
    else $error("Left aligned count skipped");
  a_zero_period: assert property (@(posedge clk) disable iff (!rst_n)
    (c.tick && per_q == RST_BYTE) |=> cnt_q == RST_BYTE)
    else $error("Zero period did not clear counter");
  a_start_level: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == RST_BYTE && per_q != RST_BYTE && dty_q != RST_BYTE)
      |-> wave_q == $past(c.pol))
    else $error("Cycle did not start at polarity");
  a_duty_flip: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q >= dty_q && per_q != RST_BYTE) |-> wave_q == !$past(c.pol))
    else $error("Output did not change at duty");

endmodule

// ### logic/pwm_timer_top.sv
`timescale 1ns/1ps
module pwm_timer_top
  import pwm_timer_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RESETN,
  input  wire logic                CLK_A_TICK,
  input  wire logic                CLK_SA_TICK,
  input  wire logic                CLK_B_TICK,
  input  wire logic                CLK_SB_TICK,
  input  wire logic [ADDR_W-1:0]   AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [DATA_W-1:0]   WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  input  wire logic [ADDR_W-1:0]   ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  output logic [DATA_W-1:0]        RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [NUM_CH-1:0]        PWM_OUT,
  output logic [NUM_CH-1:0]        PWM_OE
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                awready_q, awready_d, wready_q, wready_d;
  logic                aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic                bvalid_q, bvalid_d, arready_q, arready_d;
  logic                rvalid_q, rvalid_d;
  logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
  logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [DATA_W-1:0]   wdata_q, wdata_d, rdata_q, rdata_d;
  logic                wstrb0_q, wstrb0_d;
  logic                wr_go, wr_lane;
  logic [7:0]          wr_ofs;
  logic [1:0]          en_q, en_d, pol_q, pol_d;
  logic [1:0]          align_q, align_d, clksel_q, clksel_d;
  logic [1:0]          out_q, out_d, oe_q, oe_d;
  logic [CNT_W-1:0]    cnt_w [NUM_CH];
  logic [CNT_W-1:0]    pbuf_w [NUM_CH];
  logic [CNT_W-1:0]    dbuf_w [NUM_CH];
  logic [NUM_CH-1:0]   run_w, wave_w, tick_w;

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [7:0] o);
    is_mapped = (o == OFS_ENABLE) || (o == OFS_POL) ||
                (o == OFS_CTL) ||
                (o >= OFS_CNT0 && o < OFS_DTY0 + 2 * OFS_STRIDE);
  endfunction

  // ****************************************
  // Clock source selection
  // ****************************************
  // Channel 0 uses A or SA, channel 1 uses B or SB
  assign tick_w[0] = clksel_q[0] ? CLK_SA_TICK : CLK_A_TICK;
  assign tick_w[1] = clksel_q[1] ? CLK_SB_TICK : CLK_B_TICK;

  // ****************************************
  // Write channel
  // ****************************************
  assign wr_go = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_ofs = word_ofs(awaddr_q);
  // Only the low byte carries fields; other lanes are ignored
  assign wr_lane = wr_go & wstrb0_q;

  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awready_q && AWVALID) begin
      aw_got_d = 1'b1;
      awaddr_d = AWADDR;
      awready_d = 1'b0;
    end
    if (wready_q && WVALID) begin
      w_got_d = 1'b1;
      wdata_d = WDATA;
      wstrb0_d = WSTRB[0];
      wready_d = 1'b0;
    end
    if (wr_go) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(wr_ofs) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_comb begin
    en_d = en_q;
    pol_d = pol_q;
    align_d = align_q;
    clksel_d = clksel_q;
    if (wr_lane && wr_ofs == OFS_ENABLE) begin
      en_d = wdata_q[1:0];
    end
    if (wr_lane && wr_ofs == OFS_POL) begin
      pol_d = wdata_q[1:0];
    end
    // Changing these while running may give a ragged cycle
    if (wr_lane && wr_ofs == OFS_CTL) begin
      align_d = wdata_q[CTL_ALIGN_LSB +: 2];
      clksel_d = wdata_q[CTL_CLKSEL_LSB +: 2];
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arready_q && ARVALID) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = is_mapped(word_ofs(ARADDR)) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = '0;
      unique case (word_ofs(ARADDR))
        OFS_ENABLE: rdata_d[1:0] = en_q;
        OFS_POL: rdata_d[1:0] = pol_q;
        OFS_CTL: rdata_d[3:0] = {clksel_q, align_q};
        OFS_CNT0: rdata_d[7:0] = cnt_w[0];
        OFS_CNT0 + OFS_STRIDE: rdata_d[7:0] = cnt_w[1];
        OFS_PER0: rdata_d[7:0] = pbuf_w[0];
        OFS_PER0 + OFS_STRIDE: rdata_d[7:0] = pbuf_w[1];
        OFS_DTY0: rdata_d[7:0] = dbuf_w[0];
        OFS_DTY0 + OFS_STRIDE: rdata_d[7:0] = dbuf_w[1];
        default: rdata_d = '0;
      endcase
    end
    if (rvalid_q && RREADY) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    chan_if cif ();
    logic [7:0] cnt_ofs, per_ofs, dty_ofs;
    assign cnt_ofs = OFS_CNT0 + 8'(i * 4);
    assign per_ofs = OFS_PER0 + 8'(i * 4);
    assign dty_ofs = OFS_DTY0 + 8'(i * 4);
    assign cif.en = en_q[i];
    assign cif.pol = pol_q[i];
    assign cif.center = align_q[i];
    assign cif.tick = tick_w[i];
    assign cif.wdata = wdata_q[CNT_W-1:0];
    // Any value written to the counter restarts it
    assign cif.cnt_wr = wr_lane && wr_ofs == cnt_ofs;
    assign cif.per_wr = wr_lane && wr_ofs == per_ofs;
    assign cif.dty_wr = wr_lane && wr_ofs == dty_ofs;
    assign cnt_w[i] = cif.cnt;
    assign pbuf_w[i] = cif.per_buf;
    assign dbuf_w[i] = cif.dty_buf;
    assign run_w[i] = cif.run;
    assign wave_w[i] = cif.wave;
    chan_timer u_tmr (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .c     (cif.tmr)
    );
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_comb begin
    oe_d = en_q;
    out_d = run_w & wave_w;
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      en_q <= RST_BITS;
      pol_q <= RST_BITS;
      align_q <= RST_BITS;
      clksel_q <= RST_BITS;
      out_q <= RST_BITS;
      oe_q <= RST_BITS;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      en_q <= en_d;
      pol_q <= pol_d;
      align_q <= align_d;
      clksel_q <= clksel_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign PWM_OUT = out_q;
  assign PWM_OE = oe_q;

  // ****************************************
  // Checks
  // ****************************************
  a_oe_follows: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_lane && wr_ofs == OFS_ENABLE) |-> ##2
      PWM_OE == $past(wdata_q[1:0], 2))
    else $error("Output enable did not follow enable bit");
  a_wave_gated: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !run_w[0] |=> !PWM_OUT[0])
    else $error("Waveform shown before clock sync");
  a_sel_tick: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (clksel_q[1] && !CLK_SB_TICK &&
     !(wr_lane && wr_ofs == OFS_CNT0 + OFS_STRIDE)) |=> $stable(cnt_w[1]))
    else $error("Channel 1 counted without its selected clock");

endmodule

// ### bench/pwm_channel_timer_test.sv
`timescale 1ns/1ps
module pwm_channel_timer_test;
  import pwm_timer_pkg::*;

  // ****************************************
  // Stimulus and design instance
  // ****************************************
  localparam logic [7:0] OFS_BAD = 8'hFC;
  localparam logic [7:0] OFS_CNT1 = OFS_CNT0 + OFS_STRIDE;
  localparam logic [7:0] OFS_PER1 = OFS_PER0 + OFS_STRIDE;
  logic              clk     = 1'b0;
  logic              rst_n   = 1'b0;
  logic [3:0]        tk      = 4'h0;
  logic [7:0]        awaddr  = 8'h00;
  logic              awvalid = 1'b0;
  logic [31:0]       wdata   = 32'h0;
  logic [3:0]        wstrb   = 4'hF;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic [7:0]        araddr  = 8'h00;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]        BRESP, RRESP, PWM_OUT, PWM_OE;
  logic [31:0]       RDATA;
  int                n_fail    = 0;
  int                tests_run = 0;

  always #12.5 clk = ~clk;

  pwm_timer_top pwm_timer_top_inst (
    .CORE_CLK    (clk),
    .RESETN      (rst_n),
    .CLK_A_TICK  (tk[0]),
    .CLK_SA_TICK (tk[1]),
    .CLK_B_TICK  (tk[2]),
    .CLK_SB_TICK (tk[3]),
    .AWADDR      (awaddr),
    .AWVALID     (awvalid),
    .AWREADY     (AWREADY),
    .WDATA       (wdata),
    .WSTRB       (wstrb),
    .WVALID      (wvalid),
    .WREADY      (WREADY),
    .BRESP       (BRESP),
    .BVALID      (BVALID),
    .BREADY      (bready),
    .ARADDR      (araddr),
    .ARVALID     (arvalid),
    .ARREADY     (ARREADY),
    .RDATA       (RDATA),
    .RRESP       (RRESP),
    .RVALID      (RVALID),
    .RREADY      (rready),
    .PWM_OUT     (PWM_OUT),
    .PWM_OE      (PWM_OE)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Only the watchdog ends a wait for the response
    do begin
      @(posedge clk);
      if (awvalid && AWREADY === 1'b1) awvalid <= 1'b0;
      if (wvalid && WREADY === 1'b1) wvalid <= 1'b0;
    end while (BVALID !== 1'b1);
    cmp("bresp", {30'h0, er}, {30'h0, BRESP});
    bready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'hF, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    d = 32'hx;
    r = 2'hx;
    do begin
      @(posedge clk);
      if (arvalid && ARREADY === 1'b1) arvalid <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    cmp($sformatf("data at %0h", a), exp, d);
    cmp($sformatf("resp at %0h", a), {30'h0, er}, {30'h0, r});
  endtask

  task automatic cnt(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] r;
    rd(a, v, r);
    cmp("count in range", 32'h1, {31'h0, v < 32'h4});
  endtask

  // One pulse per selected tick, idle cycle between
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      tk <= m;
      @(posedge clk);
      tk <= 4'h0;
    end
  endtask

  // Window is a whole number of periods, so phase does not matter
  task automatic highs(input int exp);
    int k;
    k = 0;
    @(posedge clk);
    tk <= 4'h1;
    repeat (8) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      if (PWM_OUT[0] === 1'b1) k++;
    end
    tk <= 4'h0;
    cmp("high cycles", exp, k);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk(OFS_ENABLE, 32'h0, RESP_OKAY);
    chk(OFS_CTL, 32'h0, RESP_OKAY);
    chk(OFS_CNT0, 32'h0, RESP_OKAY);
    cmp("pins", 32'h0, {28'h0, PWM_OE, PWM_OUT});
    wr(OFS_BAD, 32'h1, 4'hF, RESP_SLVERR);
    chk(OFS_BAD, 32'h0, RESP_SLVERR);
    wr(OFS_ENABLE, 32'h1, 4'h0, RESP_OKAY);
    chk(OFS_ENABLE, 32'h0, RESP_OKAY);
  endtask

  task automatic t_left;
    logic [31:0] s, v;
    w(OFS_PER0, 32'h4);
    w(OFS_DTY0, 32'h1);
    w(OFS_CNT0, 32'h0);
    pulse(4'h1, 5);
    chk(OFS_CNT0, 32'h0, RESP_OKAY);
    w(OFS_ENABLE, 32'h1);
    repeat (3) @(posedge clk);
    cmp("enable pin", 32'h1, {30'h0, PWM_OE});
    cmp("out before tick", 32'h0, {31'h0, PWM_OUT[0]});
    pulse(4'h1, 1);
    cnt(OFS_CNT0, s);
    cnt(OFS_CNT0, v);
    cmp("reread", s, v);
    pulse(4'h1, 3);
    cnt(OFS_CNT0, v);
    cmp("count", (s + 32'h3) % 32'h4, v);
    pulse(4'h1, 4);
    cnt(OFS_CNT0, v);
    cmp("wrapped count", (s + 32'h3) % 32'h4, v);
  endtask

  task automatic t_wave_and_clear;
    logic [31:0] v;
    logic [1:0]  r;
    highs(30);
    w(OFS_POL, 32'h1);
    highs(10);
    pulse(4'h1, 2);
    w(OFS_CNT0, 32'hA5);
    chk(OFS_CNT0, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp("out after clear", 32'h1, {31'h0, PWM_OUT[0]});
    w(OFS_POL, 32'h0);
    repeat (3) @(posedge clk);
    cmp("out low start", 32'h0, {31'h0, PWM_OUT[0]});
    pulse(4'h1, 1);
    repeat (3) @(posedge clk);
    cmp("out at duty", 32'h1, {31'h0, PWM_OUT[0]});
    // Old period must finish before the new one counts
    w(OFS_CNT0, 32'h0);
    w(OFS_PER0, 32'h6);
    chk(OFS_PER0, 32'h6, RESP_OKAY);
    pulse(4'h1, 4);
    cnt(OFS_CNT0, v);
    cmp("old period", 32'h0, v);
    pulse(4'h1, 5);
    rd(OFS_CNT0, v, r);
    cmp("new period", 32'h5, v);
  endtask

  task automatic t_resume;
    logic [31:0] v;
    logic [1:0]  r;
    w(OFS_CNT0, 32'h0);
    pulse(4'h1, 2);
    w(OFS_ENABLE, 32'h0);
    pulse(4'h1, 3);
    chk(OFS_CNT0, 32'h2, RESP_OKAY);
    w(OFS_ENABLE, 32'h1);
    chk(OFS_CNT0, 32'h2, RESP_OKAY);
    pulse(4'h1, 1);
    rd(OFS_CNT0, v, r);
    cmp("resync tick", 32'h2, v);
    pulse(4'h1, 1);
    chk(OFS_CNT0, 32'h3, RESP_OKAY);
    w(OFS_ENABLE, 32'h0);
    w(OFS_PER0, 32'h0);
    pulse(4'h1, 1);
    chk(OFS_CNT0, 32'h0, RESP_OKAY);
    w(OFS_PER0, 32'h4);
    chk(OFS_PER0, 32'h4, RESP_OKAY);
  endtask

  task automatic t_select;
    logic [31:0] s, u, v;
    w(OFS_PER1, 32'h4);
    w(OFS_CNT1, 32'h0);
    w(OFS_CTL, 32'h4);
    w(OFS_ENABLE, 32'h3);
    pulse(4'h2, 1);
    cnt(OFS_CNT0, s);
    pulse(4'h1, 3);
    chk(OFS_CNT0, s, RESP_OKAY);
    pulse(4'h2, 1);
    chk(OFS_CNT0, (s + 32'h1) % 32'h4, RESP_OKAY);
    pulse(4'h8, 2);
    chk(OFS_CNT1, 32'h0, RESP_OKAY);
    pulse(4'h4, 1);
    cnt(OFS_CNT1, u);
    pulse(4'h4, 2);
    cnt(OFS_CNT1, v);
    cmp("ch1 count", (u + 32'h2) % 32'h4, v);
    chk(OFS_CNT0, (s + 32'h1) % 32'h4, RESP_OKAY);
    cmp("both enabled", 32'h3, {30'h0, PWM_OE});
    cmp("ch1 out", 32'h1, {31'h0, PWM_OUT[1]});
    // Mode is changed only while the channel is stopped
    w(OFS_ENABLE, 32'h1);
    w(OFS_CTL, 32'h6);
    w(OFS_CNT1, 32'h0);
    w(OFS_ENABLE, 32'h3);
    pulse(4'h4, 5);
    chk(OFS_CNT1, 32'h3, RESP_OKAY);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_left();
    t_wave_and_clear();
    t_resume();
    t_select();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles; the limit is 20000
  initial begin
    #(25 * 20000);
    n_fail++;
    print_verdict();
  end

endmodule
